// ### logic/hf_reader_frame_sequencer.sv
// Control and framing sequencer of an HF contactless reader front end.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Receiver state bits 7:4 hold the peak 4-bit logarithmic signal-strength code.
// - Peak code clears at message start and on the clear-strength command.
// - Bits 2:0 show current gain reduction, 3 dB per step, up to 21 dB.
// - Receiver state register reads zero after reset and restore-defaults.
// - Power-up gives standby with every register at its default, all zero.
// - Ready mode starts oscillator and regulators; interrupt once oscillator is stable.
// - Sending the last byte raises the end-of-transmission interrupt.
// - After transmission the receiver watches for a response and measures strength.
// - Received bytes go to FIFO; end-of-receive interrupt; status shows count.
// - Receive error or collision raises its interrupt; collision position is stored.
// - While transmitting, FIFO falling below transmit water level raises interrupt.
// - While receiving, FIFO above receive water level raises interrupt.
// - Peer operation is only 106 kbps active, selected by the peer-mode bit.
// - In peer mode the transmitter turns on only during peer transmit commands.
// - Target bit runs only the field detector; field detection raises peer event.
// - Unmask-receive command puts the receiver into receive mode.
// - Response commands run collision avoidance; external field aborts with peer event.
module hf_reader_frame_sequencer (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Host register port and direct commands.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   output logic host_interrupt,
   // Enable pin.
   input wire logic enable_pin,
   // Analog front end control and status.
   output logic osc_enable,
   output logic regulator_enable,
   input wire logic osc_stable,
   output logic tx_on,
   output logic rx_on,
   output logic field_detector_on,
   input wire logic field_detected,
   input wire logic gain_cut_b2,
   input wire logic gain_cut_b1,
   input wire logic gain_cut_b0,
   input wire logic [3:0] rssi_level,
   // Transmit byte stream towards the modulator.
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic tx_crc_on,
   // Receive byte stream from the decoder.
   input wire logic rx_begin,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_end,
   input wire logic rx_error,
   input wire logic rx_collision,
   input wire logic [7:0] rx_collision_pos
);

   function automatic logic [4:0] ptr_inc(input logic [4:0] ptr);
      ptr_inc = ptr + 5'h01;
   endfunction

   frame_seq_pkg::seq_state_type state, next_state;
   frame_seq_pkg::op_control_type op, next_op;
   logic peer_mode, next_peer_mode;
   logic [7:0] field_threshold, next_field_threshold;
   logic [15:0] tx_count, next_tx_count;
   logic [15:0] bytes_left, next_bytes_left;
   logic [7:0] collision_pos, next_collision_pos;
   logic [frame_seq_pkg::IRQ_WIDTH-1:0] irq, next_irq;
   logic [3:0] rssi_peak, next_rssi_peak;
   logic [2:0] gain_cut, next_gain_cut;
   logic osc_seen, next_osc_seen;
   logic field_seen, next_field_seen;
   logic crc_on, next_crc_on;
   logic [11:0] avoid_count, next_avoid_count;
   logic [7:0] read_data, next_read_data;
   logic [4:0] wr_ptr, next_wr_ptr;
   logic [4:0] rd_ptr, next_rd_ptr;
   logic [5:0] fifo_count, next_fifo_count;
   logic [7:0] fifo_mem [frame_seq_pkg::FIFO_DEPTH];
   logic push, pop;
   logic [7:0] push_data;
   logic tx_accept;
   logic [7:0] state_display;
   logic [7:0] op_byte;

   assign tx_accept = tx_valid && tx_ready;
   assign state_display = {rssi_peak, (op.target ? field_seen : osc_seen), gain_cut};
   assign op_byte = {op.enable, op.rx_enable, 2'b00, op.tx_enable, 2'b00, op.target};

   always_comb begin
      next_state = state;
      next_op = op;
      next_peer_mode = peer_mode;
      next_field_threshold = field_threshold;
      next_tx_count = tx_count;
      next_bytes_left = bytes_left;
      next_collision_pos = collision_pos;
      next_irq = irq;
      next_rssi_peak = rssi_peak;
      next_gain_cut = {gain_cut_b2, gain_cut_b1, gain_cut_b0};
      next_osc_seen = osc_stable;
      next_field_seen = field_detected;
      next_crc_on = crc_on;
      next_avoid_count = avoid_count;
      next_read_data = read_data;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_fifo_count = fifo_count;
      push = 1'b0;
      pop = 1'b0;
      push_data = rx_data;

      // Reading the interrupt register clears it; new events below still set.
      if (reg_read) begin
         case (reg_addr)
            frame_seq_pkg::ADDR_PROTOCOL_MODE: next_read_data = {peer_mode, 7'h00};
            frame_seq_pkg::ADDR_OP_CONTROL: next_read_data = op_byte;
            frame_seq_pkg::ADDR_COLLISION: next_read_data = collision_pos;
            frame_seq_pkg::ADDR_TX_COUNT_HI: next_read_data = tx_count[15:8];
            frame_seq_pkg::ADDR_TX_COUNT_LO: next_read_data = tx_count[7:0];
            frame_seq_pkg::ADDR_IRQ_STATUS: begin
               next_read_data = {1'b0, irq};
               next_irq = '0;
            end
            frame_seq_pkg::ADDR_FIELD_THRESHOLD: next_read_data = field_threshold;
            frame_seq_pkg::ADDR_RECEIVER_STATE: next_read_data = state_display;
            frame_seq_pkg::ADDR_FIFO_STATUS: next_read_data = {2'b00, fifo_count};
            frame_seq_pkg::ADDR_FIFO_DATA: begin
               next_read_data = fifo_mem[rd_ptr];
               pop = (fifo_count != 6'h00);
            end
            default: next_read_data = frame_seq_pkg::RESET_BYTE;
         endcase
      end
      if (reg_write) begin
         case (reg_addr)
            frame_seq_pkg::ADDR_PROTOCOL_MODE: begin
               next_peer_mode = reg_wdata[frame_seq_pkg::PEER_MODE_BIT];
            end
            frame_seq_pkg::ADDR_OP_CONTROL: begin
               next_op.enable = reg_wdata[frame_seq_pkg::OP_ENABLE_BIT];
               next_op.rx_enable = reg_wdata[frame_seq_pkg::OP_RX_ENABLE_BIT];
               next_op.tx_enable = reg_wdata[frame_seq_pkg::OP_TX_ENABLE_BIT];
               next_op.target = reg_wdata[frame_seq_pkg::OP_TARGET_BIT];
            end
            frame_seq_pkg::ADDR_TX_COUNT_HI: next_tx_count[15:8] = reg_wdata;
            frame_seq_pkg::ADDR_TX_COUNT_LO: next_tx_count[7:0] = reg_wdata;
            frame_seq_pkg::ADDR_FIELD_THRESHOLD: next_field_threshold = reg_wdata;
            frame_seq_pkg::ADDR_FIFO_DATA: begin
               push = (fifo_count != frame_seq_pkg::FIFO_FULL_COUNT);
               push_data = reg_wdata;
            end
            default: ;
         endcase
      end
      // Oscillator stable and external field events.
      if (osc_enable && osc_stable && !osc_seen) begin
         next_irq[frame_seq_pkg::IRQ_OSC_BIT] = 1'b1;
      end
      if (op.target && field_detected && !field_seen) begin
         next_irq[frame_seq_pkg::IRQ_PEER_EVENT_BIT] = 1'b1;
      end
      case (state)
         frame_seq_pkg::ST_IDLE: ;
         frame_seq_pkg::ST_TX: begin
            if (tx_accept) begin
               pop = 1'b1;
               next_bytes_left = bytes_left - 16'h0001;
               if (fifo_count == frame_seq_pkg::TX_WATER_LEVEL &&
                   bytes_left > {10'h000, fifo_count}) begin
                  next_irq[frame_seq_pkg::IRQ_WATER_BIT] = 1'b1;
               end
            end
            if (bytes_left == 16'h0000 || (tx_accept && bytes_left == 16'h0001)) begin
               next_irq[frame_seq_pkg::IRQ_TX_END_BIT] = 1'b1;
               next_state = frame_seq_pkg::ST_RX;
            end
         end
         frame_seq_pkg::ST_AVOID: begin
            if (field_detected) begin
               next_irq[frame_seq_pkg::IRQ_PEER_EVENT_BIT] = 1'b1;
               next_state = frame_seq_pkg::ST_IDLE;
            end else if (avoid_count == 12'h001) begin
               next_state = frame_seq_pkg::ST_TX;
            end else begin
               next_avoid_count = avoid_count - 12'h001;
            end
         end
         frame_seq_pkg::ST_RX: begin
            if (rssi_level > rssi_peak) next_rssi_peak = rssi_level;
            if (rx_begin) next_rssi_peak = 4'h0;
            if (rx_valid) begin
               push_data = rx_data;
               if (fifo_count == frame_seq_pkg::FIFO_FULL_COUNT) begin
                  next_irq[frame_seq_pkg::IRQ_ERROR_BIT] = 1'b1;
               end else begin
                  push = 1'b1;
                  if (fifo_count == frame_seq_pkg::RX_WATER_LEVEL) begin
                     next_irq[frame_seq_pkg::IRQ_WATER_BIT] = 1'b1;
                  end
               end
            end
            if (rx_error) next_irq[frame_seq_pkg::IRQ_ERROR_BIT] = 1'b1;
            if (rx_collision) begin
               next_irq[frame_seq_pkg::IRQ_COLLISION_BIT] = 1'b1;
               next_collision_pos = rx_collision_pos;
            end
            if (rx_end) begin
               next_irq[frame_seq_pkg::IRQ_RX_END_BIT] = 1'b1;
               next_state = frame_seq_pkg::ST_IDLE;
            end
         end
         default: next_state = frame_seq_pkg::ST_IDLE;
      endcase
      if (push) next_wr_ptr = ptr_inc(wr_ptr);
      if (pop) next_rd_ptr = ptr_inc(rd_ptr);
      if (push && !pop) begin
         next_fifo_count = fifo_count + 6'h01;
      end else if (pop && !push) begin
         next_fifo_count = fifo_count - 6'h01;
      end
      // Direct commands; transmit commands are taken only from idle or receive.
      if (cmd_valid) begin
         case (cmd_code)
            frame_seq_pkg::CMD_SET_DEFAULT: begin
               next_state = frame_seq_pkg::ST_IDLE;
               next_op = '0;
               next_peer_mode = 1'b0;
               next_field_threshold = frame_seq_pkg::RESET_BYTE;
               next_tx_count = frame_seq_pkg::RESET_COUNT;
               next_collision_pos = frame_seq_pkg::RESET_BYTE;
               next_irq = '0;
               next_rssi_peak = 4'h0;
               next_gain_cut = 3'h0;
               next_crc_on = 1'b0;
               next_wr_ptr = 5'h00;
               next_rd_ptr = 5'h00;
               next_fifo_count = 6'h00;
            end
            frame_seq_pkg::CMD_CLEAR: begin
               next_state = frame_seq_pkg::ST_IDLE;
               next_wr_ptr = 5'h00;
               next_rd_ptr = 5'h00;
               next_fifo_count = 6'h00;
            end
            frame_seq_pkg::CMD_TX_WITH_CRC, frame_seq_pkg::CMD_TX_WITHOUT_CRC: begin
               if (!peer_mode && state != frame_seq_pkg::ST_TX &&
                   state != frame_seq_pkg::ST_AVOID) begin
                  next_state = frame_seq_pkg::ST_TX;
                  next_bytes_left = tx_count;
                  next_crc_on = (cmd_code == frame_seq_pkg::CMD_TX_WITH_CRC);
               end
            end
            frame_seq_pkg::CMD_NFC_TX_INITIAL_AVOID, frame_seq_pkg::CMD_NFC_TX_RESPONSE_AVOID,
            frame_seq_pkg::CMD_NFC_TX_RESPONSE_AVOID_N0: begin
               if (peer_mode && state != frame_seq_pkg::ST_TX &&
                   state != frame_seq_pkg::ST_AVOID) begin
                  next_state = frame_seq_pkg::ST_AVOID;
                  next_avoid_count = frame_seq_pkg::AVOID_CYCLES;
                  next_bytes_left = tx_count;
                  next_crc_on = 1'b1;
               end
            end
            frame_seq_pkg::CMD_UNMASK_RX: begin
               if (state == frame_seq_pkg::ST_IDLE) next_state = frame_seq_pkg::ST_RX;
            end
            frame_seq_pkg::CMD_CLEAR_RSSI: next_rssi_peak = 4'h0;
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= frame_seq_pkg::ST_IDLE;
         op <= '0;
         peer_mode <= 1'b0;
         field_threshold <= frame_seq_pkg::RESET_BYTE;
         tx_count <= frame_seq_pkg::RESET_COUNT;
         bytes_left <= frame_seq_pkg::RESET_COUNT;
         collision_pos <= frame_seq_pkg::RESET_BYTE;
         irq <= '0;
         rssi_peak <= 4'h0;
         gain_cut <= 3'h0;
         osc_seen <= 1'b0;
         field_seen <= 1'b0;
         crc_on <= 1'b0;
         avoid_count <= 12'h000;
         read_data <= frame_seq_pkg::RESET_BYTE;
         wr_ptr <= 5'h00;
         rd_ptr <= 5'h00;
         fifo_count <= 6'h00;
      end else begin
         state <= next_state;
         op <= next_op;
         peer_mode <= next_peer_mode;
         field_threshold <= next_field_threshold;
         tx_count <= next_tx_count;
         bytes_left <= next_bytes_left;
         collision_pos <= next_collision_pos;
         irq <= next_irq;
         rssi_peak <= next_rssi_peak;
         gain_cut <= next_gain_cut;
         osc_seen <= next_osc_seen;
         field_seen <= next_field_seen;
         crc_on <= next_crc_on;
         avoid_count <= next_avoid_count;
         read_data <= next_read_data;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         fifo_count <= next_fifo_count;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (push) fifo_mem[wr_ptr] <= push_data;
   end
   assign reg_rdata = read_data;
   assign host_interrupt = |irq;
   assign osc_enable = op.enable || enable_pin;
   assign regulator_enable = op.enable || enable_pin;
   assign tx_on = peer_mode ? (state == frame_seq_pkg::ST_TX) : op.tx_enable;
   assign rx_on = op.rx_enable || state == frame_seq_pkg::ST_RX;
   assign field_detector_on = op.target || state == frame_seq_pkg::ST_AVOID;
   assign tx_data = fifo_mem[rd_ptr];
   assign tx_valid = (state == frame_seq_pkg::ST_TX) && (fifo_count != 6'h00) &&
                     (bytes_left != 16'h0000);
   assign tx_crc_on = crc_on;

endmodule // hf_reader_frame_sequencer
`default_nettype wire

// ### logic/frame_seq_pkg.sv
// Constants and types shared by the reader frame sequencer.
`default_nettype none
package frame_seq_pkg;
   // Register addresses.
   localparam logic [7:0] ADDR_PROTOCOL_MODE = 8'h01;
   localparam logic [7:0] ADDR_OP_CONTROL = 8'h02;
   localparam logic [7:0] ADDR_COLLISION = 8'h0A;
   localparam logic [7:0] ADDR_TX_COUNT_HI = 8'h0B;
   localparam logic [7:0] ADDR_TX_COUNT_LO = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h13;
   localparam logic [7:0] ADDR_FIELD_THRESHOLD = 8'h14;
   localparam logic [7:0] ADDR_RECEIVER_STATE = 8'h17;
   localparam logic [7:0] ADDR_FIFO_STATUS = 8'h1A;
   localparam logic [7:0] ADDR_FIFO_DATA = 8'h1F;
   // Field positions.
   localparam int PEER_MODE_BIT = 7;
   localparam int OP_ENABLE_BIT = 7;
   localparam int OP_RX_ENABLE_BIT = 6;
   localparam int OP_TX_ENABLE_BIT = 3;
   localparam int OP_TARGET_BIT = 0;
   localparam int IRQ_OSC_BIT = 6;
   localparam int IRQ_WATER_BIT = 5;
   localparam int IRQ_RX_END_BIT = 4;
   localparam int IRQ_TX_END_BIT = 3;
   localparam int IRQ_ERROR_BIT = 2;
   localparam int IRQ_COLLISION_BIT = 1;
   localparam int IRQ_PEER_EVENT_BIT = 0;
   localparam int IRQ_WIDTH = 7;
   // Values after reset.
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_COUNT = 16'h0000;
   // Direct command codes.
   localparam logic [7:0] CMD_SET_DEFAULT = 8'hC1;
   localparam logic [7:0] CMD_CLEAR = 8'hC2;
   localparam logic [7:0] CMD_TX_WITH_CRC = 8'hC4;
   localparam logic [7:0] CMD_TX_WITHOUT_CRC = 8'hC5;
   localparam logic [7:0] CMD_NFC_TX_INITIAL_AVOID = 8'hC8;
   localparam logic [7:0] CMD_NFC_TX_RESPONSE_AVOID = 8'hC9;
   localparam logic [7:0] CMD_NFC_TX_RESPONSE_AVOID_N0 = 8'hCA;
   localparam logic [7:0] CMD_UNMASK_RX = 8'hD1;
   localparam logic [7:0] CMD_CLEAR_RSSI = 8'hDA;
   // FIFO.
   localparam int FIFO_DEPTH = 32;
   localparam logic [5:0] FIFO_FULL_COUNT = 6'h20;
   localparam logic [5:0] TX_WATER_LEVEL = 6'h08;
   localparam logic [5:0] RX_WATER_LEVEL = 6'h18;
   // Collision avoidance listening time.
   localparam int CLK_PERIOD_NS = 50;
   localparam int AVOID_TIME_NS = 75000;
   localparam int AVOID_CYCLES_INT = (AVOID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] AVOID_CYCLES = AVOID_CYCLES_INT[11:0];

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TX = 2'b01,
      ST_AVOID = 2'b10,
      ST_RX = 2'b11
   } seq_state_type;

   typedef struct packed {
      logic enable;
      logic rx_enable;
      logic tx_enable;
      logic target;
   } op_control_type;
endpackage
`default_nettype wire

// ### tb/frame_seq_sva.sv
// Concurrent checks on the frame sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module frame_seq_sva (
   // Clock and reset.
   input wire logic clk_sys, rst,
   // Host side.
   input wire logic [7:0] reg_addr, reg_rdata,
   input wire logic reg_read, host_interrupt, enable_pin, osc_enable, regulator_enable,
   // Front end side.
   input wire logic osc_stable, tx_valid, rx_on, rx_begin, rx_valid, rx_end, rx_error,
   input wire logic rx_collision, field_detected, gain_cut_b2, gain_cut_b1, gain_cut_b0
);
   logic [2:0] gain;
   logic rd_state;
   logic rd_irq;
   assign gain = {gain_cut_b2, gain_cut_b1, gain_cut_b0};
   assign rd_state = reg_read && reg_addr == frame_seq_pkg::ADDR_RECEIVER_STATE;
   assign rd_irq = reg_read && reg_addr == frame_seq_pkg::ADDR_IRQ_STATUS;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   reset_quiet_a: assert property ($fell(rst) |-> reg_rdata == 8'h00 && !host_interrupt)
      else $error("outputs not quiet after reset");
   pin_ready_a: assert property (enable_pin |-> osc_enable && regulator_enable)
      else $error("enable pin did not start oscillator");
   osc_irq_a: assert property (osc_enable && $rose(osc_stable) |-> ##[1:3] host_interrupt)
      else $error("no interrupt after oscillator settled");
   rssi_clear_a: assert property (rx_begin ##1 rd_state |=> reg_rdata[7:4] == 4'h0)
      else $error("peak strength not cleared at message start");
   gain_show_a: assert property (rd_state && gain == $past(gain) |=> reg_rdata[2:0] == $past(gain))
      else $error("gain reduction not shown");
   tx_done_a: assert property ($fell(tx_valid) |-> host_interrupt && rx_on)
      else $error("transmit end without interrupt or receiver");
   rx_end_a: assert property (rx_end |=> host_interrupt)
      else $error("no interrupt at end of reception");
   rx_fault_a: assert property ((rx_error || rx_collision) && rx_on |=> host_interrupt)
      else $error("no interrupt on receive fault");
   irq_clear_a: assert property (rd_irq && !tx_valid && !rx_valid && !rx_end && !rx_error
      && !rx_collision && !field_detected && !$past(field_detected) && $stable(osc_stable)
      && $past(osc_stable, 2) == osc_stable |=> !host_interrupt)
      else $error("interrupt stayed after status read");
endmodule // frame_seq_sva
bind hf_reader_frame_sequencer frame_seq_sva sva_inst (.*);
`default_nettype wire

// ### tb/front_end_model.sv
// Behavioural RF front end: oscillator, modulator sink and decoder source.
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
   // Clock and pacing from the bench.
   input wire logic clk_sys,
   input wire logic slow,
   // Sequencer side.
   input wire logic osc_enable,
   input wire logic tx_on,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic osc_stable,
   output logic tx_ready,
   output logic rx_begin, rx_valid, rx_end, rx_error, rx_collision,
   output logic [7:0] rx_data, rx_collision_pos
);
   int osc_cnt = 0;
   int ntx = 0;
   logic [7:0] last_tx = 8'h00;
   logic phase = 1'b0;
   // Bytes are only taken while the transmitter is really on.
   assign tx_ready = tx_on && (!slow || phase);
   assign osc_stable = (osc_cnt == 20);
   initial begin
      {rx_begin, rx_valid, rx_end, rx_error, rx_collision} = '0;
      rx_data = 8'h00;
      rx_collision_pos = 8'h00;
   end
   always @(posedge clk_sys) begin
      osc_cnt <= osc_enable ? (osc_cnt < 20 ? osc_cnt + 1 : 20) : 0;
      phase <= ~phase;
      if (tx_valid && tx_ready) begin
         ntx <= ntx + 1;
         last_tx <= tx_data;
      end
   end
   // Data lines toggle between bytes so a stale value is never mistaken for a byte.
   task automatic frame(input int n, input logic [7:0] base, input logic bad);
      @(posedge clk_sys) rx_begin <= 1'b1;
      @(posedge clk_sys) rx_begin <= 1'b0;
      for (int i = 0; i < n; i++) begin
         rx_data <= base + 8'(i);
         rx_valid <= 1'b1;
         @(posedge clk_sys) rx_valid <= 1'b0;
         rx_data <= ~(base + 8'(i));
         @(posedge clk_sys);
      end
      rx_collision_pos <= 8'h13;
      rx_collision <= bad;
      rx_error <= bad;
      @(posedge clk_sys) {rx_collision, rx_error} <= 2'b00;
      rx_collision_pos <= 8'hEC;
      rx_end <= 1'b1;
      @(posedge clk_sys) rx_end <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
endmodule // front_end_model
`default_nettype wire

// ### tb/hf_reader_frame_sequencer_bench.sv
// Self-checking bench for the reader frame sequencer.
`timescale 1ns/1ps
`default_nettype none
module hf_reader_frame_sequencer_bench;
   localparam logic [7:0] RS = frame_seq_pkg::ADDR_RECEIVER_STATE;
   localparam logic [7:0] IRQ = frame_seq_pkg::ADDR_IRQ_STATUS;
   localparam logic [7:0] FD = frame_seq_pkg::ADDR_FIFO_DATA;
   localparam logic [7:0] FS = frame_seq_pkg::ADDR_FIFO_STATUS;
   localparam logic [7:0] OP = frame_seq_pkg::ADDR_OP_CONTROL;
   localparam logic [7:0] OSC = 8'h01 << frame_seq_pkg::IRQ_OSC_BIT;
   localparam logic [7:0] WAT = 8'h01 << frame_seq_pkg::IRQ_WATER_BIT;
   localparam logic [7:0] RXE = 8'h01 << frame_seq_pkg::IRQ_RX_END_BIT;
   localparam logic [7:0] TXE = 8'h01 << frame_seq_pkg::IRQ_TX_END_BIT;
   localparam logic [7:0] ERR = 8'h01 << frame_seq_pkg::IRQ_ERROR_BIT;
   localparam logic [7:0] COL = 8'h01 << frame_seq_pkg::IRQ_COLLISION_BIT;
   localparam logic [7:0] PEER = 8'h01 << frame_seq_pkg::IRQ_PEER_EVENT_BIT;
   logic clk_sys, rst, reg_write, reg_read, cmd_valid, enable_pin, field_detected, slow;
   logic [7:0] reg_addr, reg_wdata, cmd_code, reg_rdata, tx_data, rx_data, rx_collision_pos;
   logic host_interrupt, osc_enable, regulator_enable, osc_stable, tx_on, rx_on;
   logic field_detector_on, tx_valid, tx_ready, tx_crc_on, rx_begin, rx_valid, rx_end;
   logic rx_error, rx_collision, gain_cut_b2, gain_cut_b1, gain_cut_b0;
   logic [3:0] rssi_level;
   int n_mismatch = 0;
   int total_checks = 0;
   int t0;
   hf_reader_frame_sequencer uut (.*);
   front_end_model fe (.*);
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys) reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys) reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys) reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys) reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic cmd(input logic [7:0] c);
      @(posedge clk_sys) cmd_code <= c;
      cmd_valid <= 1'b1;
      @(posedge clk_sys) cmd_valid <= 1'b0;
   endtask
   task automatic wait_irq(input int lim);
      int i;
      for (i = 0; i < lim && host_interrupt !== 1'b1; i++) @(posedge clk_sys);
      if (i == lim) begin
         n_mismatch++;
         $display("[ERR] %0t ns: no interrupt", $time);
         close_out();
      end
   endtask
   task automatic send(input logic [7:0] cnt, input int fill, input logic [7:0] code);
      t0 = fe.ntx;
      cmd(frame_seq_pkg::CMD_CLEAR);
      wr(frame_seq_pkg::ADDR_TX_COUNT_HI, 8'h00);
      wr(frame_seq_pkg::ADDR_TX_COUNT_LO, cnt);
      for (int i = 0; i < fill; i++) wr(FD, 8'hA0 + 8'(i));
      cmd(code);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      rst = 1'b1;
      {reg_write, reg_read, cmd_valid, enable_pin, field_detected, slow} = '0;
      {reg_addr, reg_wdata, cmd_code} = '0;
      {gain_cut_b2, gain_cut_b1, gain_cut_b0, rssi_level} = '0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd(RS, 8'h00);
      rd(8'h3F, 8'h00);
      rd(IRQ, 8'h00);
      $display("reset test done");
      enable_pin <= 1'b1;
      wait_irq(100);
      rd(IRQ, OSC);
      wr(frame_seq_pkg::ADDR_PROTOCOL_MODE, 8'h00);
      wr(OP, 8'hC8);
      enable_pin <= 1'b0;
      $display("ready test done");
      {gain_cut_b2, gain_cut_b1, gain_cut_b0, rssi_level} <= {3'b101, 4'h9};
      send(8'h03, 3, frame_seq_pkg::CMD_TX_WITH_CRC);
      wait_irq(200);
      rd(IRQ, TXE);
      chk({7'h00, rx_on}, 8'h01);
      chk(fe.last_tx, 8'hA2);
      chk({7'h00, tx_crc_on}, 8'h01);
      fork
         fe.frame(2, 8'h50, 1'b0);
         begin
            @(posedge clk_sys);
            rd(RS, 8'h0D);
         end
      join
      rd(IRQ, RXE);
      rd(FS, 8'h02);
      rd(FD, 8'h50);
      rd(FD, 8'h51);
      rd(RS, 8'h9D);
      cmd(frame_seq_pkg::CMD_CLEAR_RSSI);
      rd(RS, 8'h0D);
      send(8'h01, 1, frame_seq_pkg::CMD_TX_WITHOUT_CRC);
      wait_irq(200);
      rd(IRQ, TXE);
      chk({7'h00, tx_crc_on}, 8'h00);
      fe.frame(3, 8'h60, 1'b1);
      rd(IRQ, ERR | COL | RXE);
      rd(frame_seq_pkg::ADDR_COLLISION, 8'h13);
      $display("short frame test done");
      slow <= 1'b1;
      send(8'h24, 32, frame_seq_pkg::CMD_TX_WITHOUT_CRC);
      wait_irq(400);
      rd(IRQ, WAT);
      for (int i = 0; i < 4; i++) wr(FD, 8'hC0 + 8'(i));
      wait_irq(400);
      rd(IRQ, TXE);
      chk(8'(fe.ntx - t0), 8'h24);
      chk(fe.last_tx, 8'hC3);
      slow <= 1'b0;
      fe.frame(26, 8'h00, 1'b0);
      rd(IRQ, WAT | RXE);
      rd(FS, 8'h1A);
      $display("long frame test done");
      cmd(frame_seq_pkg::CMD_SET_DEFAULT);
      {gain_cut_b2, gain_cut_b1, gain_cut_b0, rssi_level} <= '0;
      repeat (3) @(posedge clk_sys);
      rd(RS, 8'h00);
      wr(frame_seq_pkg::ADDR_PROTOCOL_MODE, 8'h80);
      wr(frame_seq_pkg::ADDR_FIELD_THRESHOLD, 8'h5A);
      wr(OP, 8'h80);
      wait_irq(100);
      rd(IRQ, OSC);
      wr(OP, 8'h81);
      #1 chk({tx_on, field_detector_on}, 8'h01);
      field_detected <= 1'b1;
      wait_irq(20);
      field_detected <= 1'b0;
      rd(IRQ, PEER);
      cmd(frame_seq_pkg::CMD_UNMASK_RX);
      #1 chk({7'h00, rx_on}, 8'h01);
      fe.frame(1, 8'h70, 1'b0);
      rd(IRQ, RXE);
      wr(OP, 8'hC0);
      send(8'h01, 1, frame_seq_pkg::CMD_NFC_TX_RESPONSE_AVOID);
      #1 chk({7'h00, field_detector_on}, 8'h01);
      field_detected <= 1'b1;
      wait_irq(50);
      rd(IRQ, PEER);
      chk({tx_valid, 7'(fe.ntx - t0)}, 8'h00);
      field_detected <= 1'b0;
      send(8'h01, 1, frame_seq_pkg::CMD_NFC_TX_INITIAL_AVOID);
      wait_irq(2000);
      rd(IRQ, TXE);
      chk(8'(fe.ntx - t0), 8'h01);
      $display("peer test done");
      close_out();
   end
endmodule // hf_reader_frame_sequencer_bench
`default_nettype wire
